// ===== tmss_regs.svh
// Purpose: Timing counts, geometry and reset values for the touch matrix scan sequencer
// Assumes: 200 MHz ref_clk
// Notes: Definitions only; included by bare name
`ifndef TMSS_REGS_SVH
`define TMSS_REGS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define TMSS_CLK_PERIOD_NS 5
// Charge capture window after each rising drive edge, fixed
`define TMSS_DWELL_NS 500
// Clamp phase after each falling edge and after the burst
`define TMSS_CLAMP_NS 500
// Least times round up to whole cycles
`define TMSS_DWELL_CYC ((`TMSS_DWELL_NS + `TMSS_CLK_PERIOD_NS - 1) / `TMSS_CLK_PERIOD_NS)
`define TMSS_CLAMP_CYC ((`TMSS_CLAMP_NS + `TMSS_CLK_PERIOD_NS - 1) / `TMSS_CLK_PERIOD_NS)

// ****************************************
// Matrix geometry
// ****************************************
`define TMSS_DRIVE_LINES 8
`define TMSS_RECEIVE_LINES 3
`define TMSS_KEYS 24
`define TMSS_KEYS_SMALL 16
`define TMSS_KEYS_LARGE 24

// ****************************************
// Per-key setup reset values
// ****************************************
`define TMSS_DIL_RESET 8'h02
`define TMSS_DIL_OFF 8'h00
`define TMSS_BURST_RESET 8'h10

`endif

// ===== tmss_pkg.sv
// Purpose: Types shared by the scan sequencer files
// Assumes: Nothing
// Notes: Constants live in tmss_regs.svh
`default_nettype none
package tmss_pkg;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        ST_FIND,
        ST_HIGH,
        ST_LOW,
        ST_CLAMP,
        ST_RAMP,
        ST_REPORT,
        ST_IDLE
    } tmss_state_type;

endpackage
`default_nettype wire

// ===== tmss_ramp_timer.sv
// Purpose: Single-slope conversion timer, ramp start to zero crossing
// Assumes: Sense inputs are asynchronous comparator levels from the pins
// Notes: Count carries a fixed two-cycle synchroniser bias
`timescale 1ns/10ps
`default_nettype none
module tmss_ramp_timer #(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ramp_start,
    input wire logic [1:0] ramp_line,
    input wire logic [2:0] receive_sense_pin,
    output logic ramp_done,
    output logic [CNT_W-1:0] ramp_count,
    output logic ramp_timeout
);

    // ****************************************
    // Parameter check
    // ****************************************
    if (CNT_W < 8 || CNT_W > 24) begin : g_bad_width
        $error("tmss_ramp_timer: CNT_W must be 8 to 24");
    end

    logic [2:0] sense_meta_q;
    logic [2:0] sense_sync_q;
    logic active_q;
    logic [1:0] line_q;
    logic [CNT_W-1:0] cnt_q;
    logic crossed;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sense_meta_q <= 3'h0;
            sense_sync_q <= 3'h0;
        end else begin
            sense_meta_q <= receive_sense_pin;
            sense_sync_q <= sense_meta_q;
        end
    end

    assign crossed = sense_sync_q[line_q];

    // Count from ramp start until the selected line crosses zero
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            active_q <= 1'b0;
            line_q <= 2'h0;
            cnt_q <= '0;
            ramp_done <= 1'b0;
            ramp_count <= '0;
            ramp_timeout <= 1'b0;
        end else begin
            ramp_done <= 1'b0;
            if (ramp_start) begin
                active_q <= 1'b1;
                line_q <= ramp_line;
                cnt_q <= '0;
            end else if (active_q) begin
                // Missing Cs or open line saturates and flags a timeout
                if (crossed || &cnt_q) begin // R15
                    active_q <= 1'b0;
                    ramp_done <= 1'b1;
                    ramp_count <= cnt_q;
                    ramp_timeout <= !crossed;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== tmss_scan_sequencer.sv
// Purpose: Scan sequencer for an 8 x 3 drive/receive capacitive key matrix
// Assumes: External Cs, ramp resistor and zero-crossing comparator per receive line
// Notes: Setup store loaded through a staged write port and an atomic commit
//
// Summary of operation
// R1 - Keys addressed only in the 8 drive by 3 receive grid, 24 positions.
// R2 - At most 16 or 24 enabled keys, chosen by variant; otherwise identical.
// R3 - Disabled keys get no timeslot; timeslots per scan equal enabled keys.
// R4 - Detect integrator limit of zero disables the key and removes its burst.
// R5 - Enabled key count never exceeds variant maximum; host must respect it.
// R6 - Small variant resets with only first two receive lines enabled.
// R7 - Host swaps in third receive line keys within one setup block load.
// R8 - Each scan begins at drive zero, receive zero, key zero.
// R9 - Drive lines zero to seven per receive line; key is receive*8+drive.
// R10 - Keys 0-7 on receive zero, 8-15 on one, 16-23 on two.
// R11 - Burst pulse count taken from each key's own setting.
// R12 - One burst finished, converted and reported before the next starts.
// R13 - Charge transfer on rising drive edge; clamp receive line on falling.
// R14 - After last pulse clamp receive line, then let Cs ramp via resistor.
// R15 - Time from ramp start to zero crossing is the measurement value.
// R16 - Capture window after each rising edge fixed at about 500 ns.
// R17 - Calibration shortens as keys are disabled, their bursts omitted.
// R18 - One calibration is exactly one full pass of the enabled-key scan.
// R19 - Drives low and clamps released between bursts; wrap to key zero.
`timescale 1ns/10ps
`default_nettype none
`include "tmss_regs.svh"
module tmss_scan_sequencer #(
    parameter int MAX_KEYS = `TMSS_KEYS_LARGE,
    parameter int CNT_W = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scan_enable,
    input wire logic cal_request,
    input wire logic setup_write,
    input wire logic [4:0] setup_key,
    input wire logic [7:0] setup_detect_integrator_limit,
    input wire logic [7:0] setup_burst_pulse_count,
    input wire logic setup_commit,
    input wire logic [2:0] receive_sense_pin,
    output logic [7:0] drive_out,
    output logic [2:0] receive_clamp,
    output logic [2:0] ramp_enable,
    output logic meas_valid,
    output logic [4:0] meas_key,
    output logic [CNT_W-1:0] meas_value,
    output logic meas_timeout,
    output logic scan_done,
    output logic cal_busy,
    output logic cal_done,
    output logic setup_reject,
    output logic [4:0] enabled_count
);

    // ****************************************
    // Parameter checks
    // ****************************************
    if (MAX_KEYS != `TMSS_KEYS_SMALL && MAX_KEYS != `TMSS_KEYS_LARGE) begin : g_bad_keys
        $error("tmss_scan_sequencer: MAX_KEYS must be 16 or 24"); // R2
    end
    if (CNT_W < 8 || CNT_W > 24) begin : g_bad_width
        $error("tmss_scan_sequencer: CNT_W must be 8 to 24");
    end

    localparam int KEYS = `TMSS_KEYS;
    localparam logic [7:0] DWELL_CYC = 8'(`TMSS_DWELL_CYC);
    localparam logic [7:0] CLAMP_CYC = 8'(`TMSS_CLAMP_CYC);
    localparam logic [4:0] KEY_LIMIT = 5'(MAX_KEYS);
    localparam logic [4:0] LAST_KEY = 5'(KEYS - 1);

    // ****************************************
    // Helper functions
    // ****************************************
    // First enabled key at or above start; bit 5 marks found
    function automatic logic [5:0] tmss_find_from(input logic [KEYS-1:0] en,
        input logic [4:0] start);
        logic [5:0] res;
        res = 6'h00;
        for (int i = KEYS - 1; i >= 0; i--) begin
            if (en[i] && 5'(i) >= start) begin
                res = {1'b1, 5'(i)};
            end
        end
        return res;
    endfunction

    // Number of enabled keys in a mask
    function automatic logic [4:0] tmss_count(input logic [KEYS-1:0] en);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < KEYS; i++) begin
            n = n + 5'(en[i]);
        end
        return n;
    endfunction

    // ****************************************
    // Setup store
    // ****************************************
    logic [7:0] dil_q [KEYS];
    logic [7:0] bl_q [KEYS];
    logic [7:0] dil_stage_q [KEYS];
    logic [7:0] bl_stage_q [KEYS];
    logic [KEYS-1:0] en_mask;
    logic [KEYS-1:0] stage_mask;
    logic commit_ok;

    // Enabled masks from the integrator limit; zero means off
    for (genvar k = 0; k < KEYS; k++) begin : g_mask
        assign en_mask[k] = (dil_q[k] != `TMSS_DIL_OFF); // R4
        assign stage_mask[k] = (dil_stage_q[k] != `TMSS_DIL_OFF);
    end

    // Commit only a staged set that the variant can serve
    assign commit_ok = (tmss_count(stage_mask) <= KEY_LIMIT); // R5

    // Reset layout and per-key storage, one generate slice per key
    for (genvar k = 0; k < KEYS; k++) begin : g_store
        // Third receive line starts off on the small variant
        localparam logic [7:0] DIL_INIT =
            (MAX_KEYS == `TMSS_KEYS_SMALL && k >= `TMSS_KEYS_SMALL) ?
            `TMSS_DIL_OFF : `TMSS_DIL_RESET;

        // Staging area; host writes freely without touching the scan
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                dil_stage_q[k] <= DIL_INIT; // R6
                bl_stage_q[k] <= `TMSS_BURST_RESET;
            end else if (setup_write && setup_key == 5'(k)) begin // R1
                dil_stage_q[k] <= setup_detect_integrator_limit;
                bl_stage_q[k] <= setup_burst_pulse_count;
            end
        end

        // Active set swaps in whole, so disable and enable land together
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                dil_q[k] <= DIL_INIT; // R6
                bl_q[k] <= `TMSS_BURST_RESET;
            end else if (setup_commit && commit_ok) begin // R7
                dil_q[k] <= dil_stage_q[k];
                bl_q[k] <= bl_stage_q[k];
            end
        end
    end

    // Commit result and live enabled count
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            setup_reject <= 1'b0;
            enabled_count <= 5'h00;
        end else begin
            if (setup_commit) begin
                setup_reject <= !commit_ok; // R5
            end
            enabled_count <= tmss_count(en_mask);
        end
    end

    // ****************************************
    // Scan state machine
    // ****************************************
    tmss_pkg::tmss_state_type state_q;
    logic [4:0] key_q;
    logic [7:0] pulses_left_q;
    logic [7:0] timer_q;
    logic first_q;
    logic [5:0] next_hit;
    logic [5:0] wrap_hit;
    logic [4:0] search_from;
    logic ramp_start;
    logic ramp_done;
    logic [CNT_W-1:0] ramp_count;
    logic ramp_timeout;
    logic wrap_now;

    // Search above the last key, or from zero on the first pass
    assign search_from = first_q ? 5'h00 : ((key_q == LAST_KEY) ? LAST_KEY : key_q + 5'h01);
    assign next_hit = (!first_q && key_q == LAST_KEY) ? 6'h00 :
                      tmss_find_from(en_mask, search_from); // R3
    assign wrap_hit = tmss_find_from(en_mask, 5'h00); // R8
    assign wrap_now = (state_q == tmss_pkg::ST_FIND) && !next_hit[5];
    assign ramp_start = (state_q == tmss_pkg::ST_CLAMP) && (timer_q == 8'h01);

    // Key walk and phase timing; one key finishes before the next begins
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_q <= tmss_pkg::ST_FIND;
            key_q <= 5'h00;
            first_q <= 1'b1;
            pulses_left_q <= 8'h00;
            timer_q <= 8'h00;
        end else begin
            case (state_q)
                tmss_pkg::ST_IDLE: begin
                    // Nothing enabled or scanning paused; restart cleanly
                    if (scan_enable && |en_mask) begin
                        state_q <= tmss_pkg::ST_FIND;
                        first_q <= 1'b1;
                    end
                end
                tmss_pkg::ST_FIND: begin
                    if (!scan_enable || !(|en_mask)) begin
                        state_q <= tmss_pkg::ST_IDLE;
                    end else begin
                        // Row order: drive index fastest, then receive line
                        key_q <= next_hit[5] ? next_hit[4:0] : wrap_hit[4:0]; // R9
                        first_q <= 1'b0;
                        pulses_left_q <= bl_q[next_hit[5] ? next_hit[4:0] : wrap_hit[4:0]]; // R11
                        timer_q <= DWELL_CYC; // R16
                        state_q <= tmss_pkg::ST_HIGH;
                    end
                end
                tmss_pkg::ST_HIGH: begin
                    // Capture window; fixed length, not adjustable
                    if (timer_q == 8'h01) begin // R16
                        timer_q <= CLAMP_CYC;
                        state_q <= tmss_pkg::ST_LOW;
                    end else begin
                        timer_q <= timer_q - 8'h01;
                    end
                end
                tmss_pkg::ST_LOW: begin
                    if (timer_q == 8'h01) begin
                        // A zero burst setting still gives one pulse
                        if (pulses_left_q <= 8'h01) begin
                            timer_q <= CLAMP_CYC;
                            state_q <= tmss_pkg::ST_CLAMP; // R14
                        end else begin
                            pulses_left_q <= pulses_left_q - 8'h01;
                            timer_q <= DWELL_CYC;
                            state_q <= tmss_pkg::ST_HIGH;
                        end
                    end else begin
                        timer_q <= timer_q - 8'h01;
                    end
                end
                tmss_pkg::ST_CLAMP: begin
                    if (timer_q == 8'h01) begin
                        state_q <= tmss_pkg::ST_RAMP; // R14
                    end else begin
                        timer_q <= timer_q - 8'h01;
                    end
                end
                tmss_pkg::ST_RAMP: begin
                    if (ramp_done) begin
                        state_q <= tmss_pkg::ST_REPORT; // R12
                    end
                end
                tmss_pkg::ST_REPORT: begin
                    state_q <= tmss_pkg::ST_FIND;
                end
                default: begin
                    state_q <= tmss_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Matrix pins
    // ****************************************
    // Pins follow the state one cycle later; all idle between bursts
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            drive_out <= 8'h00;
            receive_clamp <= 3'h0;
            ramp_enable <= 3'h0;
        end else begin
            drive_out <= 8'h00; // R19
            receive_clamp <= 3'h0; // R19
            ramp_enable <= 3'h0;
            case (state_q)
                tmss_pkg::ST_HIGH: begin
                    drive_out[key_q[2:0]] <= 1'b1; // R13
                end
                tmss_pkg::ST_LOW: begin
                    receive_clamp[key_q[4:3]] <= 1'b1; // R13
                end
                tmss_pkg::ST_CLAMP: begin
                    receive_clamp[key_q[4:3]] <= 1'b1; // R14
                end
                tmss_pkg::ST_RAMP: begin
                    ramp_enable[key_q[4:3]] <= 1'b1; // R14
                end
                default: begin
                    drive_out <= 8'h00;
                end
            endcase
        end
    end

    // ****************************************
    // Conversion
    // ****************************************
    tmss_ramp_timer #(
        .CNT_W(CNT_W)
    ) u_ramp (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .ramp_start(ramp_start),
        .ramp_line(key_q[4:3]),
        .receive_sense_pin(receive_sense_pin),
        .ramp_done(ramp_done),
        .ramp_count(ramp_count),
        .ramp_timeout(ramp_timeout)
    );

    // Result out once per key, tagged with its number
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            meas_valid <= 1'b0;
            meas_key <= 5'h00;
            meas_value <= '0;
            meas_timeout <= 1'b0;
        end else begin
            meas_valid <= 1'b0;
            if (state_q == tmss_pkg::ST_RAMP && ramp_done) begin
                meas_valid <= 1'b1;
                meas_key <= key_q; // R10
                meas_value <= ramp_count; // R15
                meas_timeout <= ramp_timeout;
            end
        end
    end

    // ****************************************
    // Scan pass and calibration
    // ****************************************
    logic cal_pend_q;

    // A wrap ends a pass; a calibration spans exactly one pass
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            scan_done <= 1'b0;
            cal_done <= 1'b0;
            cal_busy <= 1'b0;
            cal_pend_q <= 1'b0;
        end else begin
            scan_done <= 1'b0;
            cal_done <= 1'b0;
            if (wrap_now && scan_enable && |en_mask) begin
                scan_done <= 1'b1; // R19
                cal_done <= cal_busy; // R17
                cal_busy <= cal_pend_q; // R18
                // A request in the wrap cycle is kept for the next pass
                cal_pend_q <= cal_request;
            end else if (state_q == tmss_pkg::ST_FIND && first_q && next_hit[5]) begin
                // Very first pass after reset or idle starts at the lowest enabled key
                cal_busy <= cal_pend_q | cal_request; // R18
                cal_pend_q <= 1'b0;
            end else if (cal_request) begin
                cal_pend_q <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ===== tmss_matrix_model.sv
// Purpose: Receive line model, sample capacitor ramp to zero crossing
// Assumes: One comparator level per receive line, high once crossed
// Notes: Crossing after DLY_BASE plus five cycles per line
`timescale 1ns/10ps
`default_nettype none
module tmss_matrix_model #(
    parameter int DLY_BASE = 20
) (
    input wire logic ref_clk,
    input wire logic [2:0] ramp_enable,
    output logic [2:0] receive_sense_pin
);
    // ****************************************
    // Ramp timing per line
    // ****************************************
    int cnt_q [3];

    // Count only while released; a clamped line restarts from ground
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (ramp_enable[i]) begin
                cnt_q[i] <= cnt_q[i] + 1;
            end else begin
                cnt_q[i] <= 0;
            end
        end
    end

    // Low before the ramp, so no stale crossing is seen
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            receive_sense_pin[i] = cnt_q[i] >= DLY_BASE + 5 * i;
        end
    end
endmodule
`default_nettype wire

// ===== tmss_scan_checker.sv
// Purpose: Port assertions for the scan sequencer
// Assumes: One ref_clk domain, synchronous active-low reset
// Notes: Bound to every sequencer instance
`timescale 1ns/10ps
`default_nettype none
module tmss_scan_checker #(
    parameter int MAX_KEYS = 24,
    parameter int CNT_W = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] drive_out,
    input wire logic [2:0] receive_clamp,
    input wire logic [2:0] ramp_enable,
    input wire logic meas_valid,
    input wire logic [4:0] meas_key,
    input wire logic [CNT_W-1:0] meas_value,
    input wire logic meas_timeout,
    input wire logic scan_done,
    input wire logic cal_done,
    input wire logic setup_reject,
    input wire logic [4:0] enabled_count
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    // Drive pulse length
    int hi_cnt_q;
    always_ff @(posedge ref_clk) begin
        if (!resetn || !(|drive_out)) begin
            hi_cnt_q <= 0;
        end else begin
            hi_cnt_q <= hi_cnt_q + 1;
        end
    end

    // ****************************************
    // Pin and output relations
    // ****************************************
    a_dwell_fixed: assert property ($fell(|drive_out) |-> hi_cnt_q == 100)
        else $error("drive pulse not 100 cycles");
    a_drive_alone: assert property (|drive_out |-> $onehot(drive_out)
        && receive_clamp == 3'h0 && ramp_enable == 3'h0) else $error("drive overlaps");
    a_fall_clamps: assert property ($fell(|drive_out) |-> |receive_clamp)
        else $error("no clamp on falling drive");
    a_ramp_after_clamp: assert property ($rose(|ramp_enable) |->
        $past(receive_clamp) == ramp_enable) else $error("ramp without clamp");
    a_ramp_alone: assert property (|ramp_enable |-> $onehot(ramp_enable)
        && drive_out == 8'h00 && receive_clamp == 3'h0) else $error("ramp overlaps");
    a_gap_idle: assert property ($fell(|ramp_enable) |->
        (drive_out == 8'h00 && receive_clamp == 3'h0)[*2]) else $error("busy gap");
    a_valid_quiet: assert property (meas_valid |-> drive_out == 8'h00
        && receive_clamp == 3'h0 ##1 ramp_enable == 3'h0) else $error("result during burst");
    a_key_range: assert property (meas_valid |-> meas_key < 5'h18)
        else $error("key out of grid");
    a_count_cap: assert property (enabled_count <= MAX_KEYS)
        else $error("too many keys");
    a_cal_pass: assert property (cal_done |-> scan_done)
        else $error("cal end off pass end");
    a_sat_value: assert property (meas_valid && meas_timeout |-> &meas_value)
        else $error("timeout not saturated");

    c_result: cover property (meas_valid);
    c_cal: cover property (cal_done);
    c_reject: cover property ($rose(setup_reject));
endmodule

bind tmss_scan_sequencer tmss_scan_checker #(.MAX_KEYS(MAX_KEYS), .CNT_W(CNT_W)) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .drive_out(drive_out),
    .receive_clamp(receive_clamp), .ramp_enable(ramp_enable), .meas_valid(meas_valid),
    .meas_key(meas_key), .meas_value(meas_value), .meas_timeout(meas_timeout),
    .scan_done(scan_done), .cal_done(cal_done), .setup_reject(setup_reject),
    .enabled_count(enabled_count));
`default_nettype wire

// ===== touch_matrix_scan_sequencer_tb_top.sv
// Purpose: Self-checking bench for the scan sequencer, small variant
// Assumes: Model crosses at a fixed delay per line
// Notes: Short bursts keep passes near eight thousand cycles
`timescale 1ns/10ps
`default_nettype none
module touch_matrix_scan_sequencer_tb_top;
    logic ref_clk = 1'b0, resetn = 1'b0, scan_enable = 1'b0, cal_request = 1'b0;
    logic setup_write = 1'b0, setup_commit = 1'b0, watch = 1'b0, drv_prev = 1'b0;
    logic [4:0] setup_key = 5'h00;
    logic [7:0] setup_lim = 8'h00, setup_bl = 8'h00, drive_out, drv_seen;
    logic [2:0] sense, receive_clamp, ramp_enable, rmp_seen;
    logic meas_valid, meas_timeout, scan_done, cal_busy, cal_done, setup_reject;
    logic [4:0] meas_key, enabled_count;
    logic [9:0] meas_value;
    int bad_count = 0, n_compared = 0, pulses = 0, v_cnt = 0, len1, len2, k;
    int exp_q [$], bl_exp [24];

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    tmss_scan_sequencer #(.MAX_KEYS(16), .CNT_W(10)) uut (
        .ref_clk(ref_clk), .resetn(resetn), .scan_enable(scan_enable),
        .cal_request(cal_request), .setup_write(setup_write), .setup_key(setup_key),
        .setup_detect_integrator_limit(setup_lim), .setup_burst_pulse_count(setup_bl),
        .setup_commit(setup_commit), .receive_sense_pin(sense), .drive_out(drive_out),
        .receive_clamp(receive_clamp), .ramp_enable(ramp_enable), .meas_valid(meas_valid),
        .meas_key(meas_key), .meas_value(meas_value), .meas_timeout(meas_timeout),
        .scan_done(scan_done), .cal_busy(cal_busy), .cal_done(cal_done),
        .setup_reject(setup_reject), .enabled_count(enabled_count));

    tmss_matrix_model #(.DLY_BASE(20)) u_matrix (
        .ref_clk(ref_clk), .ramp_enable(ramp_enable), .receive_sense_pin(sense));

    // ****************************************
    // Shared tasks
    // ****************************************
    task check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task wrap_up;
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task tick(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task load(int key, logic [7:0] lim, logic [7:0] bl);
        setup_write = 1'b1;
        setup_key = key[4:0];
        setup_lim = lim;
        setup_bl = bl;
        bl_exp[key] = int'(bl);
        tick(1);
    endtask

    // Write strobe held across loads; reject and count settle two edges on
    task commit(logic rej, int cnt);
        setup_write = 1'b0;
        setup_commit = 1'b1;
        tick(1);
        setup_commit = 1'b0;
        tick(2);
        check("setup_reject", 32'(setup_reject), 32'(rej));
        check("enabled_count", 32'(enabled_count), cnt);
    endtask

    // Bounded wait: 0 scan_done, 1 cal_busy, 2 cal_done
    task wait_sig(int which);
        int i;
        for (i = 0; i < 20000; i++) begin
            tick(1);
            if ((which == 0 ? scan_done : which == 1 ? cal_busy : cal_done) === 1'b1) break;
        end
        check("wait", 32'(i < 20000), 1);
    endtask

    // One watched pass between two wraps; length in ns
    task run_pass(output int len);
        wait_sig(0);
        watch = 1'b1;
        len = int'($time);
        wait_sig(0);
        watch = 1'b0;
        len = int'($time) - len;
        check("slots left", exp_q.size(), 0);
    endtask

    // Pins of each key, judged at its result
    always @(negedge ref_clk) begin
        if (|drive_out && !drv_prev) pulses = pulses + 1;
        drv_prev = |drive_out;
        if (|drive_out) drv_seen = drive_out;
        if (|ramp_enable) rmp_seen = ramp_enable;
        if (meas_valid === 1'b1) begin
            v_cnt++;
            if (watch) begin
                k = exp_q.size() > 0 ? exp_q.pop_front() : 99;
                check("meas_key", 32'(meas_key), k);
                check("pulses", pulses, bl_exp[meas_key]);
                check("drive line", 32'(drv_seen), 32'(8'h01 << meas_key[2:0]));
                check("receive line", 32'(rmp_seen), 32'(3'h1 << meas_key[4:3]));
                check("meas_value", 32'(!meas_timeout && meas_value - 5 * meas_key[4:3]
                    inside {[19:24]}), 1);
            end
            pulses = 0;
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        check("reset drive", 32'(drive_out), 0);
        check("reset count", 32'(enabled_count), 16);
    endtask

    task t_order;
        for (int i = 0; i < 24; i++) load(i, i < 16 ? 8'h02 : 8'h00, 8'(i % 3 + 1));
        commit(1'b0, 16);
        scan_enable = 1'b1;
        for (int i = 0; i < 16; i++) exp_q.push_back(i);
        run_pass(len1);
    endtask

    // Key 16 refused, then swapped in for key 0
    task t_swap;
        load(16, 8'h03, 8'h02);
        commit(1'b1, 16);
        load(0, 8'h00, 8'h01);
        commit(1'b0, 16);
        for (int i = 1; i < 17; i++) exp_q.push_back(i);
        run_pass(len1);
    endtask

    task t_sparse;
        for (int i = 0; i < 24; i++) load(i, (i == 5 || i == 23) ? 8'h01 : 8'h00, 8'h01);
        commit(1'b0, 2);
        exp_q = '{5, 23};
        run_pass(len2);
        check("shorter pass", 32'(len2 < len1), 1);
    endtask

    task t_cal;
        cal_request = 1'b1;
        tick(1);
        cal_request = 1'b0;
        wait_sig(1);
        v_cnt = 0;
        wait_sig(2);
        check("cal slots", v_cnt, 2);
    endtask

    // About two and a half times the expected run length
    initial begin
        repeat (90000) @(posedge ref_clk);
        bad_count++;
        wrap_up;
    end

    initial begin
        tick(5);
        resetn = 1'b1;
        tick(2);
        t_reset;
        t_order;
        t_swap;
        t_sparse;
        t_cal;
        wrap_up;
    end
endmodule
`default_nettype wire
